//--- include/gpio_defs.vh
`ifndef GPIO_DEFS_VH
`define GPIO_DEFS_VH

// ****************************************************************
// Register byte offsets on the APB bus.
// ****************************************************************
`define OFS_DIR_CTRL     8'h00
`define OFS_PIN_OUT      8'h04
`define OFS_PIN_IN       8'h08
`define OFS_BYTE_OUT     8'h0C
`define OFS_BYTE_IN      8'h10
`define OFS_RD_LATCH     8'h14
`define OFS_IRQ_STATUS   8'h18
`define OFS_IRQ_MASK     8'h1C

// ****************************************************************
// Field positions inside the direction and control register.
// ****************************************************************
`define BIT_BUS_DIR      8
`define BIT_RD_STB_EN    9
`define BIT_WR_STB_EN    10

// ****************************************************************
// Single pin positions inside the five-bit pin vectors.
// ****************************************************************
`define PIN_FRAME        0
`define PIN_BATTERY      1
`define PIN_SUPPLY       2
`define PIN_FOUR         3
`define PIN_FIVE         4

// ****************************************************************
// Interrupt event positions in status and mask.
// ****************************************************************
`define EV_RD_STB        0
`define EV_WR_STB        1
`define EV_FRAME         2
`define EV_BATT_LOW      3
`define EV_COUNT         4

// ****************************************************************
// Reset values.
// ****************************************************************
`define RST_DIR_CTRL     11'h000
`define RST_PIN_OUT      5'h00
`define RST_BYTE         8'h00
`define RST_IRQ          4'h0

// ****************************************************************
// Timing figures and derived cycle counts.
// ****************************************************************
`define CLK_PERIOD_NS    100
`define STROBE_MIN_NS    50
`define MRST_MIN_NS      2000
`define STROBE_MIN_CYC   ((`STROBE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MRST_CYC         ((`MRST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Filter lengths at the six-bit width of the pulse qualifier's count.
`define STROBE_FILT_CYC  6'h01
`define MRST_FILT_CYC    6'h15
`define CNT_W            6

`endif

//--- src/bit_sync.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Two-stage synchroniser for asynchronous pin levels.
// ****************************************************************
module bit_sync #(
  parameter W = 1
) (
  input  wire         core_clk_i,
  input  wire         rst_i,
  input  wire         ce_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] meta_reg;  // First stage, read only by the second stage.
  reg [W-1:0] sync_reg;  // Second stage, safe for logic.

  // Both stages shift together while the clock enable is high.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_reg <= {W{1'b1}};
      sync_reg <= {W{1'b1}};
    end else if (ce_i) begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;

endmodule

`default_nettype wire

//--- src/low_pulse_detect.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Low pulse qualifier: one pulse per low period of enough length.
// ****************************************************************
module low_pulse_detect #(
  parameter [5:0] MIN_CYC = 6'h01
) (
  input  wire core_clk_i,
  input  wire rst_i,
  input  wire ce_i,
  input  wire level_i,
  output wire pulse_o
);

  reg [5:0] low_cnt_reg;  // Low samples seen, saturating at MIN_CYC.
  reg       pulse_reg;    // One-cycle detection pulse.

  // Counting restarts on every high sample, so only a falling edge
  // followed by a long enough low period produces a pulse.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      low_cnt_reg <= 6'h00;
      pulse_reg   <= 1'b0;
    end else if (ce_i) begin
      if (level_i) begin
        low_cnt_reg <= 6'h00;
        pulse_reg   <= 1'b0;
      end else if (low_cnt_reg != MIN_CYC) begin
        low_cnt_reg <= low_cnt_reg + 6'h01;
        pulse_reg   <= (low_cnt_reg == (MIN_CYC - 6'h01));
      end else begin
        pulse_reg <= 1'b0;
      end
    end
  end

  assign pulse_o = pulse_reg;

endmodule

`default_nettype wire

//--- src/gpio_strobed_byte_port.v
// The APB slave port and the register offsets are this design's own decisions.
`include "gpio_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module gpio_strobed_byte_port (
  input  wire        core_clk_i,
  input  wire        sys_rst_i,
  input  wire        ce_i,
  input  wire [7:0]  paddr_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire [4:0]  single_pins_i,
  output wire [4:0]  single_pins_o,
  output wire [4:0]  single_pins_oe_n_o,
  input  wire [7:0]  parallel_byte_lines_i,
  output wire [7:0]  parallel_byte_lines_o,
  output wire [7:0]  parallel_byte_lines_oe_n_o,
  input  wire        master_rst_n_i,
  output wire        irq_o
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  wire [4:0]  single_sync;     // Synchronised single pin levels.
  wire [7:0]  byte_sync;       // Synchronised byte bus levels.
  wire        mrst_n_sync;     // Synchronised master reset level.
  wire        mrst_pulse;      // Qualified master reset event.
  wire        rst_all;         // Reset of the port logic, apart from the synchronisers, previous levels and master reset qualifier.
  wire        rd_stb_fall;     // Qualified falling edge on pin four.
  wire        wr_stb_fall;     // Qualified falling edge on pin five.
  wire        frame_mark_pin;  // Frame start level on pin one.
  wire        battery_status_pin; // Battery status level on pin two.
  wire        rd_stb_en;       // Pin four works as read strobe.
  wire        wr_stb_en;       // Pin five works as write strobe.
  wire        rd_stb_ev;       // Read strobe accepted.
  wire        wr_stb_ev;       // Write strobe accepted.
  wire        apb_setup_wait;  // Access phase before the answer.
  wire        apb_done;        // Completing edge of a transfer.
  wire        apb_wr;          // Write takes effect now.
  wire [3:0]  ev_set;          // Hardware events this cycle.
  wire [3:0]  ev_clr;          // Software clears this cycle.

  reg  [10:0] dir_ctrl_reg;    // Directions and strobe modes.
  reg  [4:0]  pin_out_reg;     // Single pin output levels.
  reg  [4:0]  pin_oe_n_reg;    // Single pin enables, low drives.
  reg  [7:0]  byte_out_reg;    // Staged outgoing byte.
  reg  [7:0]  bus_latch_reg;   // Byte presented on the bus.
  reg  [7:0]  bus_oe_n_reg;    // Byte bus enables, low drives.
  reg  [7:0]  rd_latch_reg;    // Byte captured by a read strobe.
  reg  [4:0]  single_prev_reg; // Last synchronised single levels.
  reg  [3:0]  irq_status_reg;  // Sticky event flags.
  reg  [3:0]  irq_status_next; // Next value of the sticky flags.
  reg  [3:0]  irq_mask_reg;    // Event enables onto the interrupt.
  reg         irq_reg;         // Registered interrupt level.
  reg         pready_reg;      // Registered APB ready.
  reg         pslverr_reg;     // Registered APB error.
  reg  [31:0] prdata_reg;      // Registered APB read data.
  reg  [31:0] prdata_next;     // Read data multiplexer result.
  reg         unmapped_next;   // Address hits no register.

  // ****************************************************************
  // Pin synchronisers and strobe qualification.
  // ****************************************************************

  // Every pin level passes two flip-flops before any logic reads it.
  bit_sync #(
    .W (14)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (sys_rst_i),
    .ce_i       (ce_i),
    .d_i        ({master_rst_n_i, parallel_byte_lines_i, single_pins_i}),
    .q_o        ({mrst_n_sync, byte_sync, single_sync})
  );

  // The master reset must stay low longer than the minimum time.
  low_pulse_detect #(
    .MIN_CYC (`MRST_FILT_CYC)
  ) u_mrst_detect (
    .core_clk_i (core_clk_i),
    .rst_i      (sys_rst_i),
    .ce_i       (ce_i),
    .level_i    (mrst_n_sync),
    .pulse_o    (mrst_pulse)
  );

  // A qualified master reset clears the port registers like power-up, but not the synchronisers, previous levels or its own qualifier.
  assign rst_all = sys_rst_i | mrst_pulse;

  // Read strobe detection on pin four, from its falling edge.
  low_pulse_detect #(
    .MIN_CYC (`STROBE_FILT_CYC)
  ) u_rd_detect (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_all),
    .ce_i       (ce_i),
    .level_i    (single_sync[`PIN_FOUR]),
    .pulse_o    (rd_stb_fall)
  );

  // Write strobe detection on pin five, from its falling edge.
  low_pulse_detect #(
    .MIN_CYC (`STROBE_FILT_CYC)
  ) u_wr_detect (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_all),
    .ce_i       (ce_i),
    .level_i    (single_sync[`PIN_FIVE]),
    .pulse_o    (wr_stb_fall)
  );

  // Strobes count only while their function is selected.
  assign rd_stb_en = dir_ctrl_reg[`BIT_RD_STB_EN];
  assign wr_stb_en = dir_ctrl_reg[`BIT_WR_STB_EN];
  assign rd_stb_ev = rd_stb_en & rd_stb_fall;
  assign wr_stb_ev = wr_stb_en & wr_stb_fall;

  // Pin one and pin two carry status levels when left open.
  assign frame_mark_pin     = single_sync[`PIN_FRAME];
  assign battery_status_pin = single_sync[`PIN_BATTERY];

  // ****************************************************************
  // APB slave handshake.
  // ****************************************************************
  assign apb_setup_wait = psel_i & penable_i & ~pready_reg;
  assign apb_done       = psel_i & penable_i & pready_reg;
  assign apb_wr         = apb_done & pwrite_i & ~pslverr_reg;

  // Read data is chosen during the first access cycle and held.
  always @* begin
    prdata_next   = 32'h00000000;
    unmapped_next = 1'b0;
    case (paddr_i)
      `OFS_DIR_CTRL: begin
        prdata_next[10:0] = dir_ctrl_reg;
      end
      `OFS_PIN_OUT: begin
        prdata_next[4:0] = pin_out_reg;
      end
      `OFS_PIN_IN: begin
        prdata_next[4:0] = single_sync;
      end
      `OFS_BYTE_OUT: begin
        prdata_next[7:0] = byte_out_reg;
      end
      `OFS_BYTE_IN: begin
        prdata_next[7:0] = byte_sync;
      end
      `OFS_RD_LATCH: begin
        prdata_next[7:0] = rd_latch_reg;
      end
      `OFS_IRQ_STATUS: begin
        prdata_next[3:0] = irq_status_reg;
      end
      `OFS_IRQ_MASK: begin
        prdata_next[3:0] = irq_mask_reg;
      end
      default: begin
        unmapped_next = 1'b1;
      end
    endcase
  end

  // Ready rises one cycle into the access phase and drops after it.
  always @(posedge core_clk_i) begin
    if (rst_all) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else if (ce_i) begin
      pready_reg <= apb_setup_wait;
      if (apb_setup_wait) begin
        pslverr_reg <= unmapped_next;
        prdata_reg  <= pwrite_i ? 32'h00000000 : prdata_next;
      end else if (apb_done) begin
        pslverr_reg <= 1'b0;
        prdata_reg  <= 32'h00000000;
      end
    end
  end

  // ****************************************************************
  // Control registers and pin drivers.
  // ****************************************************************

  // Software writes steer directions, modes, levels and the mask.
  always @(posedge core_clk_i) begin
    if (rst_all) begin
      dir_ctrl_reg <= `RST_DIR_CTRL;
      pin_out_reg  <= `RST_PIN_OUT;
      irq_mask_reg <= `RST_IRQ;
    end else if (ce_i && apb_wr) begin
      case (paddr_i)
        `OFS_DIR_CTRL: begin
          dir_ctrl_reg <= pwdata_i[10:0];
        end
        `OFS_PIN_OUT: begin
          pin_out_reg <= pwdata_i[4:0];
        end
        `OFS_IRQ_MASK: begin
          irq_mask_reg <= pwdata_i[3:0];
        end
        default: begin
          dir_ctrl_reg <= dir_ctrl_reg;
        end
      endcase
    end
  end

  // Single pin enables follow the direction bits. A pin in strobe
  // mode is always an input, and pin three set as input leaves the
  // supply line to an external circuit.
  always @(posedge core_clk_i) begin
    if (rst_all) begin
      pin_oe_n_reg <= 5'h1F;
    end else if (ce_i) begin
      pin_oe_n_reg <= ~dir_ctrl_reg[4:0];
      if (rd_stb_en) begin
        pin_oe_n_reg[`PIN_FOUR] <= 1'b1;
      end
      if (wr_stb_en) begin
        pin_oe_n_reg[`PIN_FIVE] <= 1'b1;
      end
    end
  end

  // The byte bus drives together, all eight lines at once.
  always @(posedge core_clk_i) begin
    if (rst_all) begin
      bus_oe_n_reg <= 8'hFF;
    end else if (ce_i) begin
      bus_oe_n_reg <= {8{~dir_ctrl_reg[`BIT_BUS_DIR]}};
    end
  end

  // ****************************************************************
  // Byte bus transfers.
  // ****************************************************************

  // The staged byte goes to the bus at once, or on a write strobe
  // when that function is selected on pin five.
  always @(posedge core_clk_i) begin
    if (rst_all) begin
      byte_out_reg  <= `RST_BYTE;
      bus_latch_reg <= `RST_BYTE;
    end else if (ce_i) begin
      if (apb_wr && (paddr_i == `OFS_BYTE_OUT)) begin
        byte_out_reg <= pwdata_i[7:0];
        if (!wr_stb_en) begin
          bus_latch_reg <= pwdata_i[7:0];
        end
      end
      if (wr_stb_ev) begin
        bus_latch_reg <= byte_out_reg;
      end
    end
  end

  // A read strobe on pin four captures the bus into the read latch.
  always @(posedge core_clk_i) begin
    if (rst_all) begin
      rd_latch_reg <= `RST_BYTE;
    end else if (ce_i && rd_stb_ev) begin
      rd_latch_reg <= byte_sync;
    end
  end

  // ****************************************************************
  // Interrupt events.
  // ****************************************************************

  // Previous levels give the frame and battery edges. Like the
  // synchronisers they only follow the power-up reset, so a master
  // reset with a pin already low raises no false edge.
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      single_prev_reg <= 5'h1F;
    end else if (ce_i) begin
      single_prev_reg <= single_sync;
    end
  end

  // Events: strobes, frame start rising, battery status falling.
  assign ev_set[`EV_RD_STB]   = rd_stb_ev;
  assign ev_set[`EV_WR_STB]   = wr_stb_ev;
  assign ev_set[`EV_FRAME]    = frame_mark_pin & ~single_prev_reg[`PIN_FRAME] &
                                pin_oe_n_reg[`PIN_FRAME];
  assign ev_set[`EV_BATT_LOW] = ~battery_status_pin & single_prev_reg[`PIN_BATTERY] &
                                pin_oe_n_reg[`PIN_BATTERY];
  assign ev_clr = (apb_wr && (paddr_i == `OFS_IRQ_STATUS)) ? pwdata_i[3:0] : 4'h0;

  // A set arriving together with its clear keeps the flag set.
  genvar gi;
  generate
    for (gi = 0; gi < `EV_COUNT; gi = gi + 1) begin : g_flag
      always @* begin
        irq_status_next[gi] = ev_set[gi] | (irq_status_reg[gi] & ~ev_clr[gi]);
      end
    end
  endgenerate

  // Sticky flags and the masked interrupt level.
  always @(posedge core_clk_i) begin
    if (rst_all) begin
      irq_status_reg <= `RST_IRQ;
      irq_reg        <= 1'b0;
    end else if (ce_i) begin
      irq_status_reg <= irq_status_next;
      irq_reg        <= |(irq_status_next & irq_mask_reg);
    end
  end

  // ****************************************************************
  // Outputs, all straight from flip-flops.
  // ****************************************************************
  assign prdata_o                   = prdata_reg;
  assign pready_o                   = pready_reg;
  assign pslverr_o                  = pslverr_reg;
  assign single_pins_o              = pin_out_reg;
  assign single_pins_oe_n_o         = pin_oe_n_reg;
  assign parallel_byte_lines_o      = bus_latch_reg;
  assign parallel_byte_lines_oe_n_o = bus_oe_n_reg;
  assign irq_o                      = irq_reg;

endmodule

`default_nettype wire

//--- bench/gpio_port_sva.sv
`timescale 1ns/1ps
`default_nettype none

// *****
// Port checker for reset, bus handshake and pin causes.
// *****
module gpio_port_sva (
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [4:0]  single_pins_i,
  input wire logic [4:0]  single_pins_o,
  input wire logic [4:0]  single_pins_oe_n_o,
  input wire logic [7:0]  parallel_byte_lines_o,
  input wire logic [7:0]  parallel_byte_lines_oe_n_o,
  input wire logic        master_rst_n_i,
  input wire logic        irq_o
);
  // A write that completes at this edge.
  wire        apb_wr = psel_i & penable_i & pwrite_i & pready_o;
  logic       wstb_q;     // Previous write strobe level.
  logic [7:0] fall_hist;  // Recent falls of the write strobe.

  // Keeps a short history of write strobe falls.
  always @(posedge core_clk_i) begin
    wstb_q    <= single_pins_i[4];
    fall_hist <= {fall_hist[6:0], wstb_q & ~single_pins_i[4]};
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i || !master_rst_n_i);

  a_reset_pins_in: assert property (disable iff (!master_rst_n_i) sys_rst_i |=>
    single_pins_oe_n_o == 5'h1F && parallel_byte_lines_oe_n_o == 8'hFF)
    else $error("pins not inputs after reset");
  a_reset_quiet: assert property (disable iff (!master_rst_n_i) sys_rst_i |=>
    !irq_o && !pready_o && !pslverr_o && single_pins_o == 5'h00 && parallel_byte_lines_o == 8'h00)
    else $error("outputs not idle after reset");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (pready_o |-> psel_i && penable_i && $past(psel_i && penable_i))
    else $error("ready outside access phase");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  a_bus_oe_whole: assert property (parallel_byte_lines_oe_n_o == 8'h00 || parallel_byte_lines_oe_n_o == 8'hFF)
    else $error("byte bus enables split");
  a_bus_cause: assert property ($changed(parallel_byte_lines_o) |-> $past(apb_wr) || (|fall_hist))
    else $error("byte bus changed without cause");
  a_dir_cause: assert property ($changed(single_pins_oe_n_o) |-> $past(apb_wr) || $past(apb_wr, 2))
    else $error("pin direction changed without write");
  a_pins_cause: assert property ($changed(single_pins_o) |-> $past(apb_wr))
    else $error("pin level changed without write");

  c_write: cover property (apb_wr);
  c_error: cover property (pslverr_o);
  c_irq: cover property ($rose(irq_o));
endmodule

`default_nettype wire

//--- bench/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none

// *****
// External logic on the pins: levels, strobes and a byte source.
// *****
module pin_partner (
  input  wire logic       core_clk_i,
  input  wire logic [4:0] dev_pins_i,
  input  wire logic [4:0] dev_oe_n_i,
  input  wire logic [7:0] dev_bus_i,
  input  wire logic [7:0] dev_bus_oe_n_i,
  output logic      [4:0] pins_lvl_o,
  output logic      [7:0] bus_lvl_o
);
  logic [4:0] drv_pins   = 5'h1E;  // Far side levels; strobes idle high.
  logic [7:0] drv_bus    = 8'h00;  // Byte offered by the far side.
  logic       drv_bus_en = 1'b0;   // High while the far side drives the bus.
  logic [7:0] bus_last   = 8'h00;  // Last bus level, inverted when floating.

  // The device wins where it drives; a floating bus shows no stale value.
  assign pins_lvl_o = (dev_pins_i & ~dev_oe_n_i) | (drv_pins & dev_oe_n_i);
  assign bus_lvl_o  = (dev_bus_i & ~dev_bus_oe_n_i) | ((drv_bus_en ? drv_bus : ~bus_last) & dev_bus_oe_n_i);

  // Remembers the bus so a released bus toggles.
  always @(posedge core_clk_i) begin
    bus_last <= bus_lvl_o;
  end

  // Drives one single pin to a level.
  task set_pin(input int i, input logic v);
    @(posedge core_clk_i);
    drv_pins[i] <= v;
  endtask

  // Low pulse of two cycles, well above the minimum width.
  task strobe(input int i);
    @(posedge core_clk_i);
    drv_pins[i] <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    drv_pins[i] <= 1'b1;
  endtask

  // Offers a byte on the bus, or lets it go.
  task drive_bus(input logic [7:0] v, input logic en);
    @(posedge core_clk_i);
    drv_bus    <= v;
    drv_bus_en <= en;
  endtask
endmodule

`default_nettype wire

//--- bench/gpio_strobed_byte_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_defs.vh"

// *****
// Self-checking bench for the strobed byte port.
// *****
module gpio_strobed_byte_port_bench;
  logic        core_clk_i = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic        ce_i       = 1'b1;
  logic [7:0]  paddr_i    = 8'h00;
  logic        psel_i     = 1'b0;
  logic        penable_i  = 1'b0;
  logic        pwrite_i   = 1'b0;
  logic [31:0] pwdata_i   = 32'h0;
  logic        mrst_low   = 1'b0;  // Open-drain pull on the master reset.
  wire logic   master_rst_n_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        irq_o;
  logic [4:0]  pins_lvl;
  logic [4:0]  single_pins_o;
  logic [4:0]  single_pins_oe_n_o;
  logic [7:0]  bus_lvl;
  logic [7:0]  parallel_byte_lines_o;
  logic [7:0]  parallel_byte_lines_oe_n_o;
  int          failures = 0;
  int          compares = 0;
  int          cycles   = 0;

  // Released line is pulled high.
  assign master_rst_n_i = ~mrst_low;
  always #50 core_clk_i = ~core_clk_i;

  gpio_strobed_byte_port uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .single_pins_i(pins_lvl), .single_pins_o(single_pins_o), .single_pins_oe_n_o(single_pins_oe_n_o),
    .parallel_byte_lines_i(bus_lvl), .parallel_byte_lines_o(parallel_byte_lines_o),
    .parallel_byte_lines_oe_n_o(parallel_byte_lines_oe_n_o), .master_rst_n_i(master_rst_n_i), .irq_o(irq_o));

  pin_partner ptn (.core_clk_i(core_clk_i), .dev_pins_i(single_pins_o), .dev_oe_n_i(single_pins_oe_n_o),
    .dev_bus_i(parallel_byte_lines_o), .dev_bus_oe_n_i(parallel_byte_lines_oe_n_o),
    .pins_lvl_o(pins_lvl), .bus_lvl_o(bus_lvl));

  // Prints the verdict and ends the run.
  task automatic stop_test;
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Waits falling edges, where outputs are settled.
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // One bus transfer: setup, access, wait for ready, release.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge core_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    // Request stands until the edge at which ready is sampled high.
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  // Holds the master reset low for n cycles.
  task automatic mrst(input int n);
    @(posedge core_clk_i);
    mrst_low <= 1'b1;
    repeat (n) @(posedge core_clk_i);
    mrst_low <= 1'b0;
  endtask

  task automatic t_reset;
    cyc(1);
    chk(32'(single_pins_oe_n_o), 32'h1F);
    chk(32'(parallel_byte_lines_oe_n_o), 32'hFF);
    rdc(`OFS_DIR_CTRL, 32'h0);
    rdc(`OFS_IRQ_STATUS, 32'h0);
  endtask

  task automatic t_dir;
    wr(`OFS_DIR_CTRL, 32'h5);
    wr(`OFS_PIN_OUT, 32'h4);
    cyc(2);
    chk(32'(single_pins_oe_n_o), 32'h1A);
    chk(32'(single_pins_o), 32'h4);
    wr(`OFS_PIN_OUT, 32'h0);
    cyc(2);
    chk(32'(single_pins_o), 32'h0);
    ptn.set_pin(2, 1'b0);
    wr(`OFS_DIR_CTRL, 32'h0);
    cyc(2);
    chk(32'(single_pins_oe_n_o), 32'h1F);
    rdc(`OFS_PIN_IN, 32'h1A);
  endtask

  task automatic t_byte_out;
    wr(`OFS_DIR_CTRL, 32'h100);
    wr(`OFS_BYTE_OUT, 32'hA5);
    cyc(2);
    chk(32'(parallel_byte_lines_o), 32'hA5);
    chk(32'(parallel_byte_lines_oe_n_o), 32'h0);
    rdc(`OFS_BYTE_IN, 32'hA5);
  endtask

  task automatic t_rd_strobe;
    wr(`OFS_DIR_CTRL, 32'h0);
    ptn.drive_bus(8'h77, 1'b1);
    ptn.strobe(3);
    cyc(6);
    rdc(`OFS_RD_LATCH, 32'h0);
    wr(`OFS_DIR_CTRL, 32'h200);
    ptn.drive_bus(8'h3C, 1'b1);
    ptn.strobe(3);
    cyc(6);
    rdc(`OFS_RD_LATCH, 32'h3C);
    rdc(`OFS_IRQ_STATUS, 32'h1);
    wr(`OFS_IRQ_MASK, 32'h1);
    cyc(2);
    chk(32'(irq_o), 32'h1);
    wr(`OFS_IRQ_STATUS, 32'h1);
    cyc(2);
    chk(32'(irq_o), 32'h0);
  endtask

  task automatic t_wr_strobe;
    ptn.drive_bus(8'h00, 1'b0);
    wr(`OFS_DIR_CTRL, 32'h500);
    wr(`OFS_BYTE_OUT, 32'h5A);
    cyc(2);
    chk(32'(parallel_byte_lines_o), 32'hA5);
    ptn.strobe(4);
    cyc(6);
    chk(32'(parallel_byte_lines_o), 32'h5A);
    rdc(`OFS_IRQ_STATUS, 32'h2);
    wr(`OFS_IRQ_STATUS, 32'h2);
  endtask

  task automatic t_events;
    wr(`OFS_DIR_CTRL, 32'h0);
    wr(`OFS_IRQ_MASK, 32'hC);
    ce_i <= 1'b0;
    ptn.set_pin(0, 1'b1);
    cyc(6);
    chk(32'(irq_o), 32'h0);
    @(posedge core_clk_i);
    ce_i <= 1'b1;
    cyc(6);
    ptn.set_pin(1, 1'b0);
    cyc(6);
    rdc(`OFS_IRQ_STATUS, 32'hC);
    chk(32'(irq_o), 32'h1);
    wr(`OFS_IRQ_MASK, 32'h0);
    cyc(2);
    chk(32'(irq_o), 32'h0);
    wr(`OFS_IRQ_STATUS, 32'hC);
    rdc(`OFS_IRQ_STATUS, 32'h0);
  endtask

  task automatic t_refused;
    logic [31:0] r;
    logic        e;
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, 8'h20, 32'hFF, r, e);
    chk(32'(e), 32'h1);
    wr(`OFS_PIN_IN, 32'h0);
    rdc(`OFS_PIN_IN, 32'h19);
  endtask

  task automatic t_master_rst;
    wr(`OFS_DIR_CTRL, 32'h4);
    wr(`OFS_PIN_OUT, 32'h4);
    mrst(10);
    cyc(30);
    chk(32'(single_pins_o), 32'h4);
    mrst(30);
    cyc(4);
    chk(32'(single_pins_oe_n_o), 32'h1F);
    rdc(`OFS_DIR_CTRL, 32'h0);
  endtask

  // Main sequence.
  initial begin
    repeat (16) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_dir();
    t_byte_out();
    t_rd_strobe();
    t_wr_strobe();
    t_events();
    t_refused();
    t_master_rst();
    stop_test();
  end
endmodule

bind gpio_strobed_byte_port gpio_port_sva chk_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .single_pins_i(single_pins_i),
  .single_pins_o(single_pins_o), .single_pins_oe_n_o(single_pins_oe_n_o),
  .parallel_byte_lines_o(parallel_byte_lines_o), .parallel_byte_lines_oe_n_o(parallel_byte_lines_oe_n_o),
  .master_rst_n_i(master_rst_n_i), .irq_o(irq_o));

`default_nettype wire
